/* File: src/i2cc_map.vh */
/*
 * register offsets, field positions, reset values and timing counts of the
 * two-wire controller configuration block.
 * assumes a 20 MHz module clock and 16-bit byte-addressed registers.
 */
`ifndef I2CC_MAP_VH
`define I2CC_MAP_VH

// register byte addresses
`define I2CC_ADR_CTL0 16'h01C0
`define I2CC_ADR_CTL1 16'h01C2
`define I2CC_ADR_BRW 16'h01C6
`define I2CC_ADR_STAT 16'h01C8
`define I2CC_ADR_TBCNT 16'h01CA
`define I2CC_ADR_IFG 16'h01D0
`define I2CC_ADR_IE 16'h01D2

// control word zero fields
`define I2CC_C0_SWRST 0
`define I2CC_C0_CTRL 1
`define I2CC_C0_XMIT 2
`define I2CC_C0_STOPRQ 3
`define I2CC_C0_ACKRQ 4
`define I2CC_C0_RST 5'h01

// control word one fields
`define I2CC_C1_GLIT 1:0
`define I2CC_C1_ASTP 3:2
`define I2CC_C1_SWACK 4
`define I2CC_C1_STPNACK 5
`define I2CC_C1_CLTO 7:6
`define I2CC_C1_ETX 8
`define I2CC_C1_RST 9'h000
`define I2CC_BRW_RST 16'h0000
`define I2CC_TBCNT_RST 8'h00

// automatic stop codes
`define I2CC_ASTP_NONE 2'h0
`define I2CC_ASTP_FLAG 2'h1
`define I2CC_ASTP_STOP 2'h2

// status word field positions
`define I2CC_ST_SCLLOW 6
`define I2CC_ST_CNT_LSB 8

// interrupt flag positions
`define I2CC_IF_TX0 0
`define I2CC_IF_BCNT 1
`define I2CC_IF_CLTO 2
`define I2CC_IF_W 3

// clock-low timeouts in module clock cycles
`define I2CC_TO1_CYC 18'h20F58
`define I2CC_TO2_CYC 18'h249F0
`define I2CC_TO3_CYC 18'h28488

// deglitch times in picoseconds, converted to clock cycles rounding up
`define I2CC_CLK_PS 50000
`define I2CC_GL0_PS 50000
`define I2CC_GL1_PS 25000
`define I2CC_GL2_PS 12500
`define I2CC_GL3_PS 6250
`define I2CC_GL_CYC(t) (((t) + `I2CC_CLK_PS - 1) / `I2CC_CLK_PS)

`endif

/* File: src/i2cc_pinfilt.v */
/*
 * bus pin conditioner: two-flop synchroniser followed by a spike filter.
 * assumes the pin is asynchronous to clk and idles high.
 */
module i2cc_pinfilt (
    input wire clk,
    input wire reset_n,
    input wire pin_raw,
    input wire [2:0] filt_len,
    output reg pin_filt
);
    reg meta_ff;
    reg sync_ff;
    reg [2:0] run_ff;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            run_ff <= 3'h0;
            pin_filt <= 1'b1;
        end else begin
            meta_ff <= pin_raw;
            sync_ff <= meta_ff;
            // a change must persist filt_len cycles before it is passed on
            if (sync_ff == pin_filt) begin
                run_ff <= 3'h0;
            end else if (run_ff + 3'h1 >= filt_len) begin
                run_ff <= 3'h0;
                pin_filt <= sync_ff;
            end else begin
                run_ff <= run_ff + 3'h1;
            end
        end
    end
endmodule

/* File: src/i2cc_brdiv.v */
/*
 * bit clock prescaler: one tick every divisor cycles of the source clock.
 * assumes divisor is stable while run is high; 0 and 1 both tick every cycle.
 */
module i2cc_brdiv (
    input wire clk,
    input wire reset_n,
    input wire run,
    input wire [15:0] divisor,
    output reg tick
);
    reg [15:0] cnt_ff;
    wire [15:0] cnt_inc;

    assign cnt_inc = cnt_ff + 16'h0001;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 16'h0000;
            tick <= 1'b0;
        end else if (!run) begin
            cnt_ff <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_inc >= divisor) begin
            cnt_ff <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_inc;
            tick <= 1'b0;
        end
    end
endmodule

/* File: src/i2cc_cfg.v */
/*
 * configuration, byte counting, stop and acknowledge policy, clock-low
 * timeout and interrupt flags of the two-wire controller/target unit.
 * assumes a shift engine on clk that reports start, address match and
 * byte completion as one-cycle pulses, and raw bus pins from outside.
 */
// What this block does
// - target early-tx: flag on every start; else on address match asking transmit
// - timeout select 00 off, others 135000, 150000, 165000 clock cycles
// - controller receiver nacks last byte unless ack-last option is set
// - address ack by hardware, or after software ack request when selected
// - auto-stop 00: stop only on software request, threshold ignored
// - auto-stop 01: set byte-count flag at threshold, no stop
// - auto-stop 10: stop and byte-count flag at threshold; 11 reserved
// - in target mode auto-stop only gives the byte-count flag
// - bit clock is source divided by software 16-bit prescaler
// - config and prescaler writes accepted only while soft reset set
// - 8-bit threshold used only with nonzero auto-stop code
// - byte counter counts bytes since last start, read without sync
`include "i2cc_map.vh"

module i2cc_cfg #(
    parameter [17:0] TO1_CYC = `I2CC_TO1_CYC,
    parameter [17:0] TO2_CYC = `I2CC_TO2_CYC,
    parameter [17:0] TO3_CYC = `I2CC_TO3_CYC
) (
    input wire clk,
    input wire reset_n,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg irq,
    input wire scl_pin,
    input wire sda_pin,
    input wire eng_start,
    input wire eng_addr_match,
    input wire eng_dir_tx,
    input wire eng_byte_done,
    output reg soft_reset_out,
    output wire scl_clean,
    output wire sda_clean,
    output wire bit_tick,
    output reg stop_gen,
    output reg addr_ack_go,
    output reg rx_ack
);
    // filter widths in whole clock cycles; a width below one cycle still costs one
    localparam integer GL0_INT = `I2CC_GL_CYC(`I2CC_GL0_PS);
    localparam integer GL1_INT = `I2CC_GL_CYC(`I2CC_GL1_PS);
    localparam integer GL2_INT = `I2CC_GL_CYC(`I2CC_GL2_PS);
    localparam integer GL3_INT = `I2CC_GL_CYC(`I2CC_GL3_PS);

    // the filter counter is three bits wide, so only the low bits matter
    localparam [2:0] GL0_LEN = GL0_INT[2:0];
    localparam [2:0] GL1_LEN = GL1_INT[2:0];
    localparam [2:0] GL2_LEN = GL2_INT[2:0];
    localparam [2:0] GL3_LEN = GL3_INT[2:0];

    reg [4:0] ctl0_ff;
    reg [8:0] ctl1_ff;
    reg [15:0] brw_ff;
    reg [7:0] tbcnt_ff;
    reg [7:0] bcnt_ff;
    reg [17:0] to_cnt_ff;
    reg to_hit_ff;
    reg [`I2CC_IF_W-1:0] ifg_ff;
    reg [`I2CC_IF_W-1:0] ie_ff;

    reg [4:0] nxt_ctl0;
    reg [7:0] nxt_bcnt;
    reg [`I2CC_IF_W-1:0] nxt_ifg;
    reg [15:0] nxt_rdata;
    reg [2:0] filt_len;
    reg [17:0] to_limit;
    reg nxt_stop_gen;
    reg nxt_addr_ack;
    reg nxt_rx_ack;

    wire swrst;
    wire ctrl_mode;
    wire xmit;
    wire stop_rq;
    wire ack_rq;
    wire [1:0] astp;
    wire [1:0] clto;
    wire etx;
    wire swack;
    wire stpnack;
    wire wr_ctl0;
    wire wr_ctl1;
    wire wr_brw;
    wire wr_tbcnt;
    wire wr_ifg;
    wire wr_ie;
    wire [7:0] bcnt_inc;
    wire thr_hit;
    wire auto_stop;
    wire tx0_ev;
    wire bcnt_ev;
    wire last_rx_byte;
    wire [1:0] pin_raw;
    wire [1:0] pin_clean;

    assign swrst = ctl0_ff[`I2CC_C0_SWRST];
    assign ctrl_mode = ctl0_ff[`I2CC_C0_CTRL];
    assign xmit = ctl0_ff[`I2CC_C0_XMIT];
    assign stop_rq = ctl0_ff[`I2CC_C0_STOPRQ];
    assign ack_rq = ctl0_ff[`I2CC_C0_ACKRQ];
    assign astp = ctl1_ff[`I2CC_C1_ASTP];
    assign clto = ctl1_ff[`I2CC_C1_CLTO];
    assign etx = ctl1_ff[`I2CC_C1_ETX];
    assign swack = ctl1_ff[`I2CC_C1_SWACK];
    assign stpnack = ctl1_ff[`I2CC_C1_STPNACK];

    assign wr_ctl0 = reg_wr && (reg_addr == `I2CC_ADR_CTL0);
    assign wr_ctl1 = reg_wr && swrst && (reg_addr == `I2CC_ADR_CTL1);
    assign wr_brw = reg_wr && swrst && (reg_addr == `I2CC_ADR_BRW);
    assign wr_tbcnt = reg_wr && swrst && (reg_addr == `I2CC_ADR_TBCNT);
    assign wr_ifg = reg_wr && (reg_addr == `I2CC_ADR_IFG);
    assign wr_ie = reg_wr && (reg_addr == `I2CC_ADR_IE);

    assign bcnt_inc = bcnt_ff + 8'h01;
    assign thr_hit = eng_byte_done && !eng_start && (astp != `I2CC_ASTP_NONE)
        && (bcnt_inc == tbcnt_ff);
    assign bcnt_ev = thr_hit && !swrst;
    assign auto_stop = thr_hit && (astp == `I2CC_ASTP_STOP) && ctrl_mode;

    assign tx0_ev = !swrst && !ctrl_mode
        && (etx ? eng_start : (eng_addr_match && eng_dir_tx));

    // the byte about to arrive is last if a stop follows it
    assign last_rx_byte = stop_rq
        || ((astp == `I2CC_ASTP_STOP) && (bcnt_ff + 8'h02 == tbcnt_ff));

    assign pin_raw = {sda_pin, scl_pin};
    assign scl_clean = pin_clean[0];
    assign sda_clean = pin_clean[1];

    always @* begin
        case (ctl1_ff[`I2CC_C1_GLIT])
            2'h0: filt_len = GL0_LEN;
            2'h1: filt_len = GL1_LEN;
            2'h2: filt_len = GL2_LEN;
            default: filt_len = GL3_LEN;
        endcase
    end

    // both lines share one filter width so their relative timing is kept
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            i2cc_pinfilt u_filt (
                .clk(clk),
                .reset_n(reset_n),
                .pin_raw(pin_raw[gi]),
                .filt_len(filt_len),
                .pin_filt(pin_clean[gi])
            );
        end
    endgenerate

    i2cc_brdiv u_brdiv (
        .clk(clk),
        .reset_n(reset_n),
        .run(!swrst),
        .divisor(brw_ff),
        .tick(bit_tick)
    );

    always @* begin
        case (clto)
            2'h1: to_limit = TO1_CYC;
            2'h2: to_limit = TO2_CYC;
            2'h3: to_limit = TO3_CYC;
            default: to_limit = 18'h00000;
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            to_cnt_ff <= 18'h00000;
            to_hit_ff <= 1'b0;
        end else if (swrst || scl_clean || (clto == 2'h0)) begin
            to_cnt_ff <= 18'h00000;
            to_hit_ff <= 1'b0;
        end else if (to_cnt_ff + 18'h00001 >= to_limit) begin
            // holds after firing so one low period raises one event
            to_cnt_ff <= to_limit;
            to_hit_ff <= (to_cnt_ff != to_limit);
        end else begin
            to_cnt_ff <= to_cnt_ff + 18'h00001;
            to_hit_ff <= 1'b0;
        end
    end

    // control word zero, stop and ack requests
    always @* begin
        nxt_ctl0 = ctl0_ff;
        nxt_stop_gen = 1'b0;
        nxt_addr_ack = 1'b0;
        if (wr_ctl0) begin
            nxt_ctl0 = reg_wdata[4:0];
        end
        if (swrst) begin
            nxt_ctl0[`I2CC_C0_STOPRQ] = 1'b0;
            nxt_ctl0[`I2CC_C0_ACKRQ] = 1'b0;
            if (wr_ctl0) begin
                nxt_ctl0[`I2CC_C0_STOPRQ] = reg_wdata[`I2CC_C0_STOPRQ];
                nxt_ctl0[`I2CC_C0_ACKRQ] = reg_wdata[`I2CC_C0_ACKRQ];
            end
        end else begin
            if (ctrl_mode && (stop_rq || auto_stop)) begin
                nxt_stop_gen = 1'b1;
                nxt_ctl0[`I2CC_C0_STOPRQ] = 1'b0;
            end
            if (!ctrl_mode && !swack && eng_addr_match) begin
                nxt_addr_ack = 1'b1;
            end else if (!ctrl_mode && swack && ack_rq) begin
                nxt_addr_ack = 1'b1;
                nxt_ctl0[`I2CC_C0_ACKRQ] = 1'b0;
            end
        end
    end

    always @* begin
        nxt_rx_ack = 1'b1;
        if (ctrl_mode && !xmit && !stpnack && last_rx_byte) begin
            nxt_rx_ack = 1'b0;
        end
    end

    always @* begin
        nxt_bcnt = bcnt_ff;
        if (swrst || eng_start) begin
            nxt_bcnt = 8'h00;
        end else if (eng_byte_done) begin
            nxt_bcnt = bcnt_inc;
        end
    end

    // sticky flags: a new event beats a same-cycle clear
    always @* begin
        nxt_ifg = ifg_ff;
        if (wr_ifg) begin
            nxt_ifg = ifg_ff & ~reg_wdata[`I2CC_IF_W-1:0];
        end
        if (tx0_ev) begin
            nxt_ifg[`I2CC_IF_TX0] = 1'b1;
        end
        if (bcnt_ev) begin
            nxt_ifg[`I2CC_IF_BCNT] = 1'b1;
        end
        if (to_hit_ff) begin
            nxt_ifg[`I2CC_IF_CLTO] = 1'b1;
        end
    end

    // read mux, unmapped addresses read zero
    always @* begin
        nxt_rdata = 16'h0000;
        case (reg_addr)
            `I2CC_ADR_CTL0: nxt_rdata = {11'h000, ctl0_ff};
            `I2CC_ADR_CTL1: nxt_rdata = {7'h00, ctl1_ff};
            `I2CC_ADR_BRW: nxt_rdata = brw_ff;
            `I2CC_ADR_STAT: begin
                nxt_rdata[15:`I2CC_ST_CNT_LSB] = bcnt_ff;
                nxt_rdata[`I2CC_ST_SCLLOW] = !scl_clean;
            end
            `I2CC_ADR_TBCNT: nxt_rdata = {8'h00, tbcnt_ff};
            `I2CC_ADR_IFG: nxt_rdata = {13'h0000, ifg_ff};
            `I2CC_ADR_IE: nxt_rdata = {13'h0000, ie_ff};
            default: nxt_rdata = 16'h0000;
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl0_ff <= `I2CC_C0_RST;
            ctl1_ff <= `I2CC_C1_RST;
            brw_ff <= `I2CC_BRW_RST;
            tbcnt_ff <= `I2CC_TBCNT_RST;
            bcnt_ff <= 8'h00;
            ifg_ff <= 3'h0;
            ie_ff <= 3'h0;
            reg_rdata <= 16'h0000;
            irq <= 1'b0;
            soft_reset_out <= 1'b1;
            stop_gen <= 1'b0;
            addr_ack_go <= 1'b0;
            rx_ack <= 1'b1;
        end else begin
            ctl0_ff <= nxt_ctl0;
            if (wr_ctl1) begin
                ctl1_ff <= reg_wdata[8:0];
            end
            if (wr_brw) begin
                brw_ff <= reg_wdata;
            end
            if (wr_tbcnt) begin
                tbcnt_ff <= reg_wdata[7:0];
            end
            if (wr_ie) begin
                ie_ff <= reg_wdata[`I2CC_IF_W-1:0];
            end
            bcnt_ff <= nxt_bcnt;
            ifg_ff <= nxt_ifg;
            // read data stand only in the cycle after the strobe
            reg_rdata <= reg_rd ? nxt_rdata : 16'h0000;
            irq <= |(nxt_ifg & ie_ff);
            soft_reset_out <= nxt_ctl0[`I2CC_C0_SWRST];
            stop_gen <= nxt_stop_gen;
            addr_ack_go <= nxt_addr_ack;
            rx_ack <= nxt_rx_ack;
        end
    end
endmodule

/* File: testbench/i2cc_cfg_props.sv */
/* assertion checker of the two-wire configuration block.
   sees only top ports; shadows the control writes it needs. */
`include "i2cc_map.vh"
module i2cc_cfg_props #(
    parameter [17:0] TO1_CYC = 18'h20F58,
    parameter [17:0] TO2_CYC = 18'h249F0,
    parameter [17:0] TO3_CYC = 18'h28488
) (
    input wire clk,
    input wire reset_n,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire scl_pin,
    input wire eng_start,
    input wire eng_addr_match,
    input wire eng_byte_done,
    input wire scl_clean,
    input wire bit_tick,
    input wire stop_gen,
    input wire addr_ack_go,
    input wire rx_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [2:0] c0_ff;
    reg [8:0] c1_ff;
    reg [7:0] thr_ff;
    reg [7:0] cnt_ff;
    wire wr0 = reg_wr && reg_addr == `I2CC_ADR_CTL0;
    wire run = !c0_ff[0];
    // shadows follow the lock, so a leaky lock shows up as a bad stop or ack
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            c0_ff <= 3'h1;
            c1_ff <= 9'h000;
            thr_ff <= 8'h00;
            cnt_ff <= 8'h00;
        end else begin
            if (wr0) c0_ff <= reg_wdata[2:0];
            if (reg_wr && !run && reg_addr == `I2CC_ADR_CTL1) c1_ff <= reg_wdata[8:0];
            if (reg_wr && !run && reg_addr == `I2CC_ADR_TBCNT) thr_ff <= reg_wdata[7:0];
            if (!run || eng_start) cnt_ff <= 8'h00;
            else if (eng_byte_done) cnt_ff <= cnt_ff + 8'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_last_byte;
        run && c0_ff[1] && eng_byte_done && c1_ff[3:2] == 2'h2 && cnt_ff + 8'h01 == thr_ff;
    endsequence
    sequence s_near_last;
        run && c0_ff[2:1] == 2'h1 && !c1_ff[5] && c1_ff[3:2] == 2'h2
            && cnt_ff + 8'h02 == thr_ff;
    endsequence
    a_auto_stop: assert property (s_last_byte |=> stop_gen)
        else $error("no stop at threshold");
    a_target_no_stop: assert property (!c0_ff[1] && !$past(c0_ff[1]) |-> !stop_gen)
        else $error("stop from target");
    a_soft_stop: assert property (run && wr0 && reg_wdata[3:0] == 4'hA |-> ##[1:3] stop_gen)
        else $error("stop request lost");
    a_auto_addr_ack: assert property (
        run && !c0_ff[1] && !c1_ff[4] && eng_addr_match |=> addr_ack_go)
        else $error("no address ack");
    a_sw_addr_ack: assert property (
        run && !c0_ff[1] && c1_ff[4] && wr0 && reg_wdata[4:0] == 5'h10 |-> ##[1:3] addr_ack_go)
        else $error("ack request lost");
    a_reset_quiet: assert property (
        c0_ff[0] && $past(c0_ff[0]) |-> !(stop_gen || addr_ack_go || bit_tick))
        else $error("activity in soft reset");
    a_last_nack: assert property (s_near_last |=> !rx_ack)
        else $error("last byte acked");
    a_deglitch_pass: assert property (scl_pin [*6] |-> scl_clean)
        else $error("clean clock stuck low");
endmodule
bind i2cc_cfg i2cc_cfg_props #(
    .TO1_CYC(TO1_CYC), .TO2_CYC(TO2_CYC), .TO3_CYC(TO3_CYC)) u_props (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .scl_pin(scl_pin), .eng_start(eng_start),
    .eng_addr_match(eng_addr_match), .eng_byte_done(eng_byte_done),
    .scl_clean(scl_clean), .bit_tick(bit_tick), .stop_gen(stop_gen),
    .addr_ack_go(addr_ack_go), .rx_ack(rx_ack));

/* File: testbench/i2cc_remote.sv */
/* remote bus device: stretches the clock line low on request.
   assumes pulled-up lines; a released line reads high. */
module i2cc_remote (
    input wire clk,
    input wire hold_go,
    input wire [7:0] hold_len,
    output wire scl_pin,
    output wire sda_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left_ff = 8'h00;
    always @(posedge clk) begin
        if (hold_go) left_ff <= hold_len;
        else if (left_ff != 8'h00) left_ff <= left_ff - 8'h01;
    end
    assign scl_pin = (left_ff == 8'h00);
    assign sda_pin = 1'h1;
endmodule

/* File: testbench/tb_top.sv */
/* self-checking bench of the two-wire configuration block.
   assumes the remote model stretches the clock line on request. */
`include "i2cc_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, hold_go = 1'h0;
    logic eng_start = 1'h0, eng_addr_match = 1'h0, eng_dir_tx = 1'h0, eng_byte_done = 1'h0;
    logic [7:0] hold_len = 8'h00;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, rd_val;
    wire [15:0] reg_rdata;
    wire irq, scl_pin, sda_pin, scl_clean, bit_tick, stop_gen, addr_ack_go, rx_ack;
    wire soft_rst_seen, sda_clean;
    int fail_count = 0, tests_run = 0, stops = 0, acks = 0, ticks = 0, n0;
    int lims [0:3] = '{20, 20, 30, 40};
    // address, reset value, write data, read back
    logic [15:0] rows_r [0:4][0:3] = '{
        '{`I2CC_ADR_CTL1, 16'h0000, 16'hFFFF, 16'h01FF},
        '{`I2CC_ADR_BRW, 16'h0000, 16'hABCD, 16'hABCD},
        '{`I2CC_ADR_TBCNT, 16'h0000, 16'h1234, 16'h0034},
        '{`I2CC_ADR_STAT, 16'h0000, 16'hFFFF, 16'h0000},
        '{16'h01E0, 16'h0000, 16'hFFFF, 16'h0000}};
    // control zero, control one, stops, flags, ack after first byte
    logic [15:0] rows_a [0:5][0:4] = '{
        '{16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0001},
        '{16'h0002, 16'h0004, 16'h0000, 16'h0002, 16'h0001},
        '{16'h0002, 16'h0008, 16'h0001, 16'h0002, 16'h0000},
        '{16'h0002, 16'h0028, 16'h0001, 16'h0002, 16'h0001},
        '{16'h0000, 16'h0008, 16'h0000, 16'h0002, 16'h0001},
        '{16'h0006, 16'h0008, 16'h0001, 16'h0002, 16'h0001}};
    // short timeouts keep the run brief
    i2cc_cfg #(.TO1_CYC(18'h00014), .TO2_CYC(18'h0001E), .TO3_CYC(18'h00028)) dut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .scl_pin(scl_pin), .sda_pin(sda_pin), .eng_start(eng_start),
        .eng_addr_match(eng_addr_match), .eng_dir_tx(eng_dir_tx),
        .eng_byte_done(eng_byte_done), .soft_reset_out(soft_rst_seen), .scl_clean(scl_clean),
        .sda_clean(sda_clean), .bit_tick(bit_tick), .stop_gen(stop_gen),
        .addr_ack_go(addr_ack_go), .rx_ack(rx_ack));
    i2cc_remote peer (.clk(clk), .hold_go(hold_go), .hold_len(hold_len),
        .scl_pin(scl_pin), .sda_pin(sda_pin));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        stops <= stops + (stop_gen === 1'h1);
        acks <= acks + (addr_ack_go === 1'h1);
        ticks <= ticks + (bit_tick === 1'h1);
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic flags(input logic [15:0] e);
        rd(`I2CC_ADR_IFG);
        chk("flags", e, rd_val);
    endtask
    // engine pulse: start, match, direction, byte done
    task automatic ev(input logic [3:0] e);
        @(posedge clk);
        {eng_start, eng_addr_match, eng_dir_tx, eng_byte_done} <= e;
        @(posedge clk);
        {eng_start, eng_addr_match, eng_dir_tx, eng_byte_done} <= 4'h0;
        repeat (3) @(posedge clk);
    endtask
    // control one and threshold go in under soft reset, the only time they are taken
    task automatic cfg(input logic [15:0] c0, input logic [15:0] c1);
        wr(`I2CC_ADR_CTL0, 16'h0001);
        wr(`I2CC_ADR_CTL1, c1);
        wr(`I2CC_ADR_TBCNT, 16'h0003);
        wr(`I2CC_ADR_IE, 16'h0007);
        wr(`I2CC_ADR_IFG, 16'h0007);
        wr(`I2CC_ADR_CTL0, c0);
    endtask
    task automatic hold(input int n);
        @(posedge clk);
        hold_len <= 8'(n);
        hold_go <= 1'h1;
        @(posedge clk);
        hold_go <= 1'h0;
        repeat (n + 8) @(posedge clk);
    endtask
    initial begin
        #(20000 * 50);
        fail_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        rd(`I2CC_ADR_CTL0);
        chk("ctl0 reset", 16'h0001, rd_val);
        chk("soft reset out", 16'h0001, {15'h0000, soft_rst_seen});
        chk("sda clean idle", 16'h0001, {15'h0000, sda_clean});
        foreach (rows_r[i]) begin
            rd(rows_r[i][0]);
            chk("reset value", rows_r[i][1], rd_val);
            wr(rows_r[i][0], rows_r[i][2]);
            rd(rows_r[i][0]);
            chk("read back", rows_r[i][3], rd_val);
        end
        foreach (rows_a[i]) begin
            cfg(rows_a[i][0], rows_a[i][1]);
            n0 = stops;
            ev(4'h8);
            ev(4'h1);
            chk("first ack", rows_a[i][4], {15'h0000, rx_ack});
            ev(4'h1);
            ev(4'h1);
            chk("stops", rows_a[i][2], 16'(stops - n0));
            flags(rows_a[i][3]);
            chk("irq", {15'h0000, |rows_a[i][3]}, {15'h0000, irq});
            rd(`I2CC_ADR_STAT);
            chk("byte count", 16'h0300, rd_val & 16'hFF00);
        end
        wr(`I2CC_ADR_CTL1, 16'h0155);
        rd(`I2CC_ADR_CTL1);
        chk("locked ctl1", 16'h0008, rd_val);
        wr(`I2CC_ADR_CTL0, 16'h0001);
        wr(`I2CC_ADR_BRW, 16'h0004);
        wr(`I2CC_ADR_CTL0, 16'h0002);
        repeat (8) @(posedge clk);
        n0 = ticks;
        repeat (40) @(posedge clk);
        chk("ticks", 16'h000A, 16'(ticks - n0));
        cfg(16'h0002, 16'h0000);
        n0 = stops;
        wr(`I2CC_ADR_CTL0, 16'h000A);
        repeat (4) @(posedge clk);
        cfg(16'h0000, 16'h0000);
        wr(`I2CC_ADR_CTL0, 16'h0008);
        repeat (4) @(posedge clk);
        chk("software stops", 16'h0001, 16'(stops - n0));
        cfg(16'h0000, 16'h0100); // target mode, early-tx flag on every start
        ev(4'h8);
        flags(16'h0001);
        cfg(16'h0000, 16'h0000);
        ev(4'h8);
        flags(16'h0000);
        n0 = acks;
        ev(4'h6);
        flags(16'h0001);
        chk("auto ack", 16'h0001, 16'(acks - n0));
        cfg(16'h0000, 16'h0010);
        ev(4'h4);
        chk("held ack", 16'h0001, 16'(acks - n0));
        wr(`I2CC_ADR_CTL0, 16'h0010);
        repeat (4) @(posedge clk);
        chk("software ack", 16'h0002, 16'(acks - n0));
        for (int k = 0; k < 4; k++) begin
            cfg(16'h0002, 16'((k << 6) | k)); // every filter code
            hold(lims[k] - 6);
            flags(16'h0000);
            hold(lims[k] + 8);
            flags(k != 0 ? 16'h0004 : 16'h0000);
        end
        chk("soft reset run", 16'h0000, {15'h0000, soft_rst_seen});
        test_done();
    end
endmodule
